// ==== verilog/csb_regs.vh ====
// Purpose: register map, field positions and codes of the compare/skip/branch unit
// Assumes: included by bare name from the design files
// Notes: byte addresses on an AXI4-Lite bus with 32-bit words
`ifndef CSB_REGS_VH
`define CSB_REGS_VH

`define CSB_ADDR_W 8
`define CSB_OFS_CMD 8'h00
`define CSB_OFS_PC 8'h04
`define CSB_OFS_FLAGS 8'h08
`define CSB_OFS_STATUS 8'h0C
`define CSB_OFS_REGSEL 8'h10
`define CSB_OFS_REGDATA 8'h14

// command word fields
`define CSB_CMD_OP_LSB 0
`define CSB_CMD_BIT_LSB 4
`define CSB_CMD_TWO_WORD 7
`define CSB_CMD_RD_LSB 8
`define CSB_CMD_RR_LSB 16
`define CSB_CMD_K_LSB 24

// operation codes
`define CSB_OP_CMP 4'h0
`define CSB_OP_CMPC 4'h1
`define CSB_OP_CMPI 4'h2
`define CSB_OP_SKRC 4'h3
`define CSB_OP_SKRS 4'h4
`define CSB_OP_SKIC 4'h5
`define CSB_OP_SKIS 4'h6
`define CSB_OP_BRFS 4'h7
`define CSB_OP_BRFC 4'h8
`define CSB_OP_BRANCH_EQUAL 4'h9

// status flag bit positions
`define CSB_FLAG_C 0
`define CSB_FLAG_Z 1
`define CSB_FLAG_N 2
`define CSB_FLAG_V 3
`define CSB_FLAG_S 4
`define CSB_FLAG_H 5

// status register fields
`define CSB_ST_BUSY 0
`define CSB_ST_TAKEN 1
`define CSB_ST_BADOP 2
`define CSB_ST_CYC_LSB 4

// reset values
`define CSB_PC_RST 16'h0000
`define CSB_FLAGS_RST 8'h00

// pc steps and cycle counts
`define CSB_PC_STEP 16'h0001
`define CSB_SKIP_SHORT 16'h0002
`define CSB_SKIP_LONG 16'h0003
`define CSB_CYC_ONE 3'h1
`define CSB_CYC_TWO 3'h2
`define CSB_CYC_THREE 3'h3

// axi responses
`define CSB_RESP_OKAY 2'h0
`define CSB_RESP_SLVERR 2'h2

`endif

// ==== verilog/csb_regfile.v ====
// Purpose: working register file, one write port and two registered read ports
// Assumes: single clock; read data appear one edge after the address
// Notes: a read of the word being written returns the old value for one cycle
`timescale 1ns/1ps
`default_nettype none
module csb_regfile #(
	parameter DEPTH = 32,
	parameter AW = 5,
	parameter DW = 8
) (
	input wire clock_in,
	input wire wr_en_in,
	input wire [AW-1:0] wr_addr_in,
	input wire [DW-1:0] wr_data_in,
	input wire [AW-1:0] rd_addr_a_in,
	input wire [AW-1:0] rd_addr_b_in,
	output reg [DW-1:0] rd_data_a_out,
	output reg [DW-1:0] rd_data_b_out
);
	reg [DW-1:0] mem [0:DEPTH-1];

	// no reset on the array so it maps onto ram; contents are set by software
	always @(posedge clock_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
		rd_data_a_out <= mem[rd_addr_a_in];
		rd_data_b_out <= mem[rd_addr_b_in];
	end
endmodule // csb_regfile
`default_nettype wire

// ==== verilog/csb_exec.v ====
// Purpose: executes compares, bit skips and flag branches on an 8-bit core state
// Assumes: AXI4-Lite master keeps one read and one write outstanding at most
// Notes: a command write starts one instruction; cycle cost is reported in status
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "csb_regs.vh"

// Overview of operation
// [RQ1] compare: rd minus rr sets Z N V C H
// [RQ2] compare with carry subtracts carry too
// [RQ3] compare immediate: rd minus constant, flags set
// [RQ4] skip when register bit clear, flags kept
// [RQ5] skip when register bit set, flags kept
// [RQ6] skip when io bit clear, flags kept
// [RQ7] skip when io bit set, flags kept
// [RQ8] branch pc+k+1 when selected flag set
// [RQ9] branch pc+k+1 when selected flag clear
// [RQ10] branch pc+k+1 when zero flag set
// [RQ11] two-word skipped instruction: step 3, cost 3
module csb_exec #(
	parameter PC_W = 16,
	parameter REG_DEPTH = 32
) (
	input wire clock_in,
	input wire reset_n_in,
	input wire [`CSB_ADDR_W-1:0] s_axi_awaddr_in,
	input wire s_axi_awvalid_in,
	output reg s_axi_awready_out,
	input wire [31:0] s_axi_wdata_in,
	input wire [3:0] s_axi_wstrb_in,
	input wire s_axi_wvalid_in,
	output reg s_axi_wready_out,
	output reg [1:0] s_axi_bresp_out,
	output reg s_axi_bvalid_out,
	input wire s_axi_bready_in,
	input wire [`CSB_ADDR_W-1:0] s_axi_araddr_in,
	input wire s_axi_arvalid_in,
	output reg s_axi_arready_out,
	output reg [31:0] s_axi_rdata_out,
	output reg [1:0] s_axi_rresp_out,
	output reg s_axi_rvalid_out,
	input wire s_axi_rready_in,
	output reg [7:0] io_addr_out,
	input wire [7:0] io_data_in,
	output reg [PC_W-1:0] pc_out,
	output reg [7:0] status_flags_register_out,
	output reg done_out
);
	localparam ST_IDLE = 2'h0;
	localparam ST_READ = 2'h1;
	localparam ST_EXEC = 2'h2;

	reg [1:0] state_ff;
	reg [`CSB_ADDR_W-1:0] awaddr_ff;
	reg [31:0] wdata_ff;
	reg [3:0] wstrb_ff;
	reg aw_have_ff;
	reg w_have_ff;
	reg [31:0] cmd_ff;
	reg [4:0] regsel_ff;
	reg taken_ff;
	reg badop_ff;
	reg [2:0] cycles_ff;
	reg [PC_W-1:0] nxt_pc;
	reg [7:0] nxt_flags;
	reg nxt_taken;
	reg nxt_badop;
	reg [2:0] nxt_cycles;
	reg [7:0] res;
	reg [7:0] sub_b;
	reg carry_in;
	reg test_bit;
	reg [31:0] rd_word;
	reg rd_ok;
	reg wr_ok;

	wire [7:0] rd_a;
	wire [7:0] rd_b;
	wire aw_hs = s_axi_awvalid_in & s_axi_awready_out;
	wire w_hs = s_axi_wvalid_in & s_axi_wready_out;
	wire ar_hs = s_axi_arvalid_in & s_axi_arready_out;
	wire wr_go = aw_have_ff & w_have_ff & ~s_axi_bvalid_out;
	wire busy = (state_ff != ST_IDLE);
	wire [3:0] op = cmd_ff[`CSB_CMD_OP_LSB +: 4];
	wire [2:0] bsel = cmd_ff[`CSB_CMD_BIT_LSB +: 3];
	wire [7:0] k_field = cmd_ff[`CSB_CMD_K_LSB +: 8];
	wire two_word = cmd_ff[`CSB_CMD_TWO_WORD];
	wire start = wr_go & wr_ok & (awaddr_ff == `CSB_OFS_CMD) & wstrb_ff[0] & ~busy;
	wire regdata_wr = wr_go & wr_ok & (awaddr_ff == `CSB_OFS_REGDATA) & wstrb_ff[0];
	// while idle port a follows the software selector for regdata reads
	wire [4:0] addr_a = busy ? cmd_ff[`CSB_CMD_RD_LSB +: 5] : regsel_ff;

	csb_regfile #(
		.DEPTH(REG_DEPTH),
		.AW(5),
		.DW(8)
	) u_regfile (
		.clock_in(clock_in),
		.wr_en_in(regdata_wr),
		.wr_addr_in(regsel_ff),
		.wr_data_in(wdata_ff[7:0]),
		.rd_addr_a_in(addr_a),
		.rd_addr_b_in(cmd_ff[`CSB_CMD_RR_LSB +: 5]),
		.rd_data_a_out(rd_a),
		.rd_data_b_out(rd_b)
	);

	always @* begin
		wr_ok = 1'b1;
		if (awaddr_ff == `CSB_OFS_CMD) begin
			wr_ok = 1'b1;
		end else if (awaddr_ff == `CSB_OFS_PC) begin
			wr_ok = 1'b1;
		end else if (awaddr_ff == `CSB_OFS_FLAGS) begin
			wr_ok = 1'b1;
		end else if (awaddr_ff == `CSB_OFS_REGSEL) begin
			wr_ok = 1'b1;
		end else if (awaddr_ff == `CSB_OFS_REGDATA) begin
			wr_ok = 1'b1;
		end else begin
			wr_ok = 1'b0;
		end
	end

	always @* begin
		rd_word = 32'h00000000;
		rd_ok = 1'b1;
		if (s_axi_araddr_in == `CSB_OFS_CMD) begin
			rd_word = cmd_ff;
		end else if (s_axi_araddr_in == `CSB_OFS_PC) begin
			rd_word[PC_W-1:0] = pc_out;
		end else if (s_axi_araddr_in == `CSB_OFS_FLAGS) begin
			rd_word[7:0] = status_flags_register_out;
		end else if (s_axi_araddr_in == `CSB_OFS_STATUS) begin
			rd_word[`CSB_ST_BUSY] = busy;
			rd_word[`CSB_ST_TAKEN] = taken_ff;
			rd_word[`CSB_ST_BADOP] = badop_ff;
			rd_word[`CSB_ST_CYC_LSB +: 3] = cycles_ff;
		end else if (s_axi_araddr_in == `CSB_OFS_REGSEL) begin
			rd_word[4:0] = regsel_ff;
		end else if (s_axi_araddr_in == `CSB_OFS_REGDATA) begin
			rd_word[7:0] = rd_a;
		end else begin
			rd_ok = 1'b0;
		end
	end

	// instruction datapath, evaluated in ST_EXEC with operands from the register file
	always @* begin
		nxt_pc = pc_out + `CSB_PC_STEP;
		nxt_flags = status_flags_register_out;
		nxt_taken = 1'b0;
		nxt_badop = 1'b0;
		nxt_cycles = `CSB_CYC_ONE;
		sub_b = (op == `CSB_OP_CMPI) ? k_field : rd_b; // [RQ3]
		carry_in = (op == `CSB_OP_CMPC) ? status_flags_register_out[`CSB_FLAG_C] : 1'b0; // [RQ2]
		res = rd_a - sub_b - {7'h00, carry_in}; // [RQ1]
		test_bit = 1'b0;
		case (op)
			`CSB_OP_CMP, `CSB_OP_CMPC, `CSB_OP_CMPI: begin
				nxt_flags[`CSB_FLAG_H] = (~rd_a[3] & sub_b[3]) | (sub_b[3] & res[3]) | (res[3] & ~rd_a[3]);
				nxt_flags[`CSB_FLAG_V] = (rd_a[7] & ~sub_b[7] & ~res[7]) | (~rd_a[7] & sub_b[7] & res[7]);
				nxt_flags[`CSB_FLAG_N] = res[7];
				nxt_flags[`CSB_FLAG_S] = res[7] ^ nxt_flags[`CSB_FLAG_V];
				nxt_flags[`CSB_FLAG_C] = (~rd_a[7] & sub_b[7]) | (sub_b[7] & res[7]) | (res[7] & ~rd_a[7]);
				// with carry, a zero result only keeps Z so multi-byte compares chain
				if (op == `CSB_OP_CMPC) begin
					nxt_flags[`CSB_FLAG_Z] = (res == 8'h00) & status_flags_register_out[`CSB_FLAG_Z]; // [RQ2]
				end else begin
					nxt_flags[`CSB_FLAG_Z] = (res == 8'h00); // [RQ1] [RQ3]
				end
			end
			`CSB_OP_SKRC, `CSB_OP_SKRS, `CSB_OP_SKIC, `CSB_OP_SKIS: begin
				if (op == `CSB_OP_SKRC || op == `CSB_OP_SKRS) begin
					test_bit = rd_a[bsel]; // [RQ4] [RQ5]
				end else begin
					test_bit = io_data_in[bsel]; // [RQ6] [RQ7]
				end
				nxt_taken = (op == `CSB_OP_SKRS || op == `CSB_OP_SKIS) ? test_bit : ~test_bit;
				if (nxt_taken) begin
					nxt_pc = pc_out + (two_word ? `CSB_SKIP_LONG : `CSB_SKIP_SHORT); // [RQ11]
					nxt_cycles = two_word ? `CSB_CYC_THREE : `CSB_CYC_TWO; // [RQ11]
				end
			end
			`CSB_OP_BRFS, `CSB_OP_BRFC, `CSB_OP_BRANCH_EQUAL: begin
				if (op == `CSB_OP_BRANCH_EQUAL) begin
					nxt_taken = status_flags_register_out[`CSB_FLAG_Z]; // [RQ10]
				end else if (op == `CSB_OP_BRFS) begin
					nxt_taken = status_flags_register_out[bsel]; // [RQ8]
				end else begin
					nxt_taken = ~status_flags_register_out[bsel]; // [RQ9]
				end
				if (nxt_taken) begin
					// offset is 7-bit signed, sign-extended to the pc width
					nxt_pc = pc_out + {{(PC_W-7){k_field[6]}}, k_field[6:0]} + `CSB_PC_STEP; // [RQ8] [RQ9] [RQ10]
					nxt_cycles = `CSB_CYC_TWO;
				end
			end
			default: begin
				nxt_pc = pc_out;
				nxt_badop = 1'b1;
			end
		endcase
	end

	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out <= 1'b1;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= `CSB_RESP_OKAY;
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h00000000;
			s_axi_rresp_out <= `CSB_RESP_OKAY;
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			awaddr_ff <= {`CSB_ADDR_W{1'b0}};
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			state_ff <= ST_IDLE;
			cmd_ff <= 32'h00000000;
			regsel_ff <= 5'h00;
			pc_out <= `CSB_PC_RST;
			status_flags_register_out <= `CSB_FLAGS_RST;
			io_addr_out <= 8'h00;
			taken_ff <= 1'b0;
			badop_ff <= 1'b0;
			cycles_ff <= 3'h0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (aw_hs) begin
				awaddr_ff <= s_axi_awaddr_in;
				aw_have_ff <= 1'b1;
				s_axi_awready_out <= 1'b0;
			end
			if (w_hs) begin
				wdata_ff <= s_axi_wdata_in;
				wstrb_ff <= s_axi_wstrb_in;
				w_have_ff <= 1'b1;
				s_axi_wready_out <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= wr_ok ? `CSB_RESP_OKAY : `CSB_RESP_SLVERR;
				aw_have_ff <= 1'b0;
				w_have_ff <= 1'b0;
			end
			if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
				s_axi_awready_out <= 1'b1;
				s_axi_wready_out <= 1'b1;
			end
			if (ar_hs) begin
				s_axi_arready_out <= 1'b0;
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out <= rd_word;
				s_axi_rresp_out <= rd_ok ? `CSB_RESP_OKAY : `CSB_RESP_SLVERR;
			end
			if (s_axi_rvalid_out && s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
				s_axi_arready_out <= 1'b1;
			end
			// software writes to pc and flags are dropped while an instruction runs
			if (wr_go && !busy) begin
				if (awaddr_ff == `CSB_OFS_PC) begin
					pc_out <= wdata_ff[PC_W-1:0];
				end else if (awaddr_ff == `CSB_OFS_FLAGS && wstrb_ff[0]) begin
					status_flags_register_out <= wdata_ff[7:0];
				end
			end
			if (wr_go && awaddr_ff == `CSB_OFS_REGSEL && wstrb_ff[0]) begin
				regsel_ff <= wdata_ff[4:0];
			end
			case (state_ff)
				ST_IDLE: begin
					if (start) begin
						cmd_ff <= wdata_ff;
						io_addr_out <= wdata_ff[`CSB_CMD_K_LSB +: 8];
						state_ff <= ST_READ;
					end
				end
				ST_READ: begin
					state_ff <= ST_EXEC;
				end
				ST_EXEC: begin
					// skips and branches leave every flag as it was
					status_flags_register_out <= nxt_flags; // [RQ4] [RQ5] [RQ6] [RQ7] [RQ8] [RQ9]
					pc_out <= nxt_pc;
					taken_ff <= nxt_taken;
					badop_ff <= nxt_badop;
					cycles_ff <= nxt_cycles;
					done_out <= 1'b1;
					state_ff <= ST_IDLE;
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end
endmodule // csb_exec
`default_nettype wire

// ==== bench/csb_exec_sva.sv ====
// Purpose: port checks for the compare/skip/branch unit
// Assumes: no command word is written while an instruction runs
// Notes: op and offset come from the last write data taken
`timescale 1ns/1ps
`default_nettype none
module csb_exec_sva #(parameter PC_W = 16) (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic [PC_W-1:0] pc_out,
	input wire logic [7:0] status_flags_register_out,
	input wire logic done_out
);
	logic [31:0] cmd_ff;
	logic is_cmd_ff;
	wire logic [3:0] op = cmd_ff[3:0];
	wire logic [PC_W-1:0] koff = {{(PC_W-7){cmd_ff[30]}}, cmd_ff[30:24]};
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cmd_ff <= 32'h0;
			is_cmd_ff <= 1'b0;
		end else begin
			if (s_axi_wvalid_in && s_axi_wready_out)
				cmd_ff <= s_axi_wdata_in;
			if (s_axi_awvalid_in && s_axi_awready_out)
				is_cmd_ff <= s_axi_awaddr_in == 8'h00;
		end
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);
	sequence s_wr_taken;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	// every op code, bad ones too, ends with a done pulse
	sequence s_cmd_ack;
		$rose(s_axi_bvalid_out) && is_cmd_ff;
	endsequence
	// both halves are registered first, so bvalid shows two edges after the take
	a_write_answer: assert property (s_wr_taken |=> ##1 s_axi_bvalid_out)
		else $error("write response late");
	a_bvalid_stands: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
		else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out)
		else $error("read response late");
	a_exec_latency: assert property (s_cmd_ack |=> !done_out ##1 done_out)
		else $error("done not two cycles after command");
	a_done_pulse: assert property (done_out |=> !done_out)
		else $error("done longer than one cycle");
	a_bad_op_pc: assert property (done_out && op > 4'h9 |-> $stable(pc_out))
		else $error("bad op moved pc");
	a_cmp_pc: assert property (done_out && op <= 4'h2 |-> pc_out - $past(pc_out) == 1'b1)
		else $error("compare pc step wrong");
	a_skip_pc: assert property (done_out && op inside {[4'h3:4'h6]} |->
		pc_out - $past(pc_out) == 1'b1 || pc_out - $past(pc_out) == {1'b1, cmd_ff[7]})
		else $error("skip pc step wrong");
	a_flags_kept: assert property (done_out && op inside {[4'h3:4'h9]} |-> $stable(status_flags_register_out))
		else $error("flags changed by skip or branch");
	a_branch_target: assert property (done_out && op inside {[4'h7:4'h9]} |->
		pc_out - $past(pc_out) == 1'b1 || pc_out - $past(pc_out) - koff == 1'b1)
		else $error("branch target wrong");
endmodule // csb_exec_sva
bind csb_exec csb_exec_sva #(.PC_W(PC_W)) u_sva (.clock_in, .reset_n_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
	.s_axi_awready_out, .s_axi_wdata_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in,
	.s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out, .pc_out, .status_flags_register_out, .done_out);
`default_nettype wire

// ==== bench/test_compare_skip_branch_exec.sv ====
// Purpose: directed bench for the compare/skip/branch unit
// Assumes: one bus transfer at a time, inputs change just after rising edges
// Notes: expected flags come from a local subtract model
`timescale 1ns/1ps
`default_nettype none
module test_compare_skip_branch_exec;
	logic clock_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, io_data = 8'h00;
	logic [31:0] wdata = 32'h0, st;
	logic [1:0] r;
	wire logic awready, wready, bvalid, arready, rvalid, done;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0] io_addr, flags;
	wire logic [15:0] pc;
	int mismatches = 0, tests_run = 0, cycles = 0;
	csb_exec dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .io_addr_out(io_addr),
		.io_data_in(io_data), .pc_out(pc), .status_flags_register_out(flags), .done_out(done));
	always #2.5 clock_in = ~clock_in;
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic a_ok, w_ok;
		a_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clock_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(a_ok && w_ok)) begin
			@(posedge clock_in);
			if (awready && !a_ok)
				awvalid <= 1'b0;
			if (wready && !w_ok)
				wvalid <= 1'b0;
			a_ok = a_ok | awready;
			w_ok = w_ok | wready;
		end
		do @(posedge clock_in); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge clock_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock_in); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clock_in); while (rvalid !== 1'b1);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic set_reg(input logic [7:0] idx, input logic [7:0] v);
		wr(8'h10, {24'h0, idx}, r);
		wr(8'h14, {24'h0, v}, r);
	endtask
	// pc is loaded first so every step is measured from a known base
	task automatic run(input logic [31:0] cmd, input logic [15:0] pc0);
		wr(8'h04, {16'h0, pc0}, r);
		wr(8'h00, cmd, r);
		do @(posedge clock_in); while (done !== 1'b1);
		rd(8'h0C, st, r);
	endtask
	function automatic logic [7:0] f_sub(input logic [3:0] op, input logic [7:0] a, b, f);
		logic [7:0] d;
		logic h, v, c, z;
		d = a - b - ((op == 4'h1) ? f[0] : 1'b0);
		h = (~a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~a[3]);
		v = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
		c = (~a[7] & b[7]) | (b[7] & d[7]) | (d[7] & ~a[7]);
		z = (d == 8'h00) && (op != 4'h1 || f[1]);
		return {f[7:6], h, d[7] ^ v, v, d[7], z, c};
	endfunction
	task automatic t_bus();
		check("pc reset", pc, 32'h0);
		check("flags reset", flags, 32'h0);
		check("io addr reset", io_addr, 32'h0);
		check("bus reset", {awready, wready, arready, bvalid, rvalid, done}, 32'h38);
		wr(8'h20, 32'h1, r);
		check("bresp unmapped", r, 32'h2);
		rd(8'h20, st, r);
		check("rresp unmapped", r, 32'h2);
		check("rdata unmapped", st, 32'h0);
		set_reg(8'h03, 8'h5A);
		rd(8'h14, st, r);
		check("regdata", st, 32'h5A);
	endtask
	task automatic do_cmp(input logic [3:0] op, input logic [7:0] a, b, f);
		set_reg(8'h01, a);
		set_reg(8'h02, b);
		wr(8'h08, {24'h0, f}, r);
		run({b, 8'h02, 8'h01, 4'h0, op}, 16'h0040);
		check("cmp flags", flags, f_sub(op, a, b, f));
		check("cmp pc", pc, 32'h41);
		check("cmp cost", {st[1], st[6:4]}, 32'h1);
	endtask
	// an undefined op code must leave pc and flags alone and raise badop
	task automatic t_bad();
		wr(8'h08, 32'h5A, r);
		run(32'h0000000F, 16'h0200);
		check("bad op pc", pc, 32'h200);
		check("bad op flags", flags, 32'h5A);
		check("bad op status", st[2:0], 32'h4);
	endtask
	task automatic t_compare();
		do_cmp(4'h0, 8'h10, 8'h20, 8'h00);
		do_cmp(4'h1, 8'h80, 8'h01, 8'h03);
		do_cmp(4'h1, 8'h05, 8'h05, 8'h02);
		do_cmp(4'h2, 8'h42, 8'h42, 8'hC0);
	endtask
	task automatic t_skip();
		logic tk;
		for (int op = 3; op <= 6; op++)
			for (int v = 0; v < 2; v++)
				for (int tw = 0; tw < 2; tw++) begin
					tk = (op == 3 || op == 5) ? (v == 0) : (v == 1);
					io_data <= v ? 8'h20 : 8'hDF;
					set_reg(8'h03, v ? 8'h20 : 8'hDF);
					wr(8'h08, 32'hA5, r);
					run({8'h37, 8'h03, 8'h03, tw[0], 3'd5, op[3:0]}, 16'h0100);
					check("skip io addr", io_addr, 32'h37);
					check("skip flags", flags, 32'hA5);
					check("skip pc", pc, 32'h101 + (tk ? 1 + tw : 0));
					check("skip cost", {st[1], st[6:4]}, tk ? 10 + tw : 1);
				end
	endtask
	task automatic t_branch();
		logic tk;
		logic [6:0] k;
		logic [15:0] e;
		for (int op = 7; op <= 9; op++)
			for (int fv = 0; fv < 2; fv++)
				for (int i = 0; i < 2; i++) begin
					k = i ? 7'h7D : 7'h05;
					tk = (op == 8) ? (fv == 0) : (fv == 1);
					e = tk ? 16'h0101 + {{9{k[6]}}, k} : 16'h0101;
					wr(8'h08, fv ? 32'h0A : 32'hF5, r);
					run({1'b0, k, 16'h0, 4'h3, op[3:0]}, 16'h0100);
					check("branch flags", flags, fv ? 32'h0A : 32'hF5);
					check("branch pc", pc, e);
					check("branch cost", {st[1], st[6:4]}, tk ? 32'hA : 32'h1);
				end
	endtask
	initial begin
		repeat (2) @(posedge clock_in);
		reset_n_in <= 1'b1;
		t_bus();
		t_compare();
		t_skip();
		t_branch();
		t_bad();
		tally_and_finish();
	end
endmodule // test_compare_skip_branch_exec
`default_nettype wire
